// *** hdl/olim_pkg.sv ***
// Purpose: shared constants of the output frequency limiter
// Assumes: frequencies in 0.1 Hz steps, 16-bit unsigned
// Notes: the disable code lies above every legal frequency
package olim_pkg;
  // ********************************
  // frequency scale
  // ********************************
  localparam int FW = 16;
  localparam logic [FW-1:0] F_ZERO = 16'h0000;
  localparam logic [FW-1:0] F_120HZ = 16'h04b0;
  localparam logic [FW-1:0] F_400HZ = 16'h0fa0;
  localparam logic [FW-1:0] F_DISABLED = 16'h270f;
  // ********************************
  // reset values
  // ********************************
  localparam logic [FW-1:0] MAX_RST = F_120HZ;
  localparam logic [FW-1:0] MIN_RST = F_ZERO;
  localparam logic [FW-1:0] HSMAX_RST = F_120HZ;
  localparam logic [FW-1:0] JUMP_RST = F_DISABLED;
  localparam logic [FW-1:0] JOG_RST = 16'h0032;
  localparam logic [FW-1:0] START_RST = 16'h0005;
  // ********************************
  // setting select codes
  // ********************************
  localparam int NBAND = 3;
  localparam int SW = 4;
  localparam logic [SW-1:0] SEL_MAX = 4'h0;
  localparam logic [SW-1:0] SEL_MIN = 4'h1;
  localparam logic [SW-1:0] SEL_HSMAX = 4'h2;
  localparam logic [SW-1:0] SEL_JOG = 4'h3;
  localparam logic [SW-1:0] SEL_START = 4'h4;
  localparam logic [SW-1:0] SEL_JUMP0 = 4'h8;
  localparam logic [SW-1:0] SEL_JUMP_LAST = 4'hd;
  localparam logic [7:0] EXT_OPEN = 8'h00;
  typedef enum logic [2:0] {
    OLIM_IDLE = 3'b001,
    OLIM_RUN = 3'b010,
    OLIM_JOG = 3'b100
  } olim_mode_t;
endpackage

// *** hdl/olim_jump_if.sv ***
// Purpose: carries a command and the jump band edges to the band skipper
// Assumes: one clock domain, purely combinational path
// Notes: edges hold A then B for each band in turn
interface olim_jump_if;
  logic [olim_pkg::FW-1:0] cmd;
  logic [olim_pkg::FW-1:0] edges [2*olim_pkg::NBAND];
  logic [olim_pkg::FW-1:0] result;
  modport calc (input cmd, input edges, output result);
  modport user (output cmd, output edges, input result);
endinterface

// *** hdl/olim_jump.sv ***
// Purpose: moves a command lying inside an enabled jump band to its lower edge
// Assumes: bands given as two unordered edges
// Notes: combinational
module olim_jump (
  // band edges and command
  olim_jump_if.calc jp
);
  logic [olim_pkg::NBAND-1:0] hit;
  logic [olim_pkg::FW-1:0] lo [olim_pkg::NBAND];
  // ********************************
  // per band detection
  // ********************************
  for (genvar b = 0; b < olim_pkg::NBAND; b++) begin : g_band
    logic [olim_pkg::FW-1:0] ea;
    logic [olim_pkg::FW-1:0] eb;
    logic [olim_pkg::FW-1:0] hi;
    assign ea = jp.edges[2*b];
    assign eb = jp.edges[2*b+1];
    assign lo[b] = (ea < eb) ? ea : eb;
    assign hi = (ea < eb) ? eb : ea;
    assign hit[b] = (ea != olim_pkg::F_DISABLED) && (eb != olim_pkg::F_DISABLED)
      && (jp.cmd > lo[b]) && (jp.cmd < hi);
  end
  // ********************************
  // lowest numbered band wins
  // ********************************
  always_comb begin
    jp.result = jp.cmd;
    for (int b = olim_pkg::NBAND - 1; b >= 0; b--) begin
      if (hit[b]) begin
        jp.result = lo[b];
      end
    end
  end
endmodule

// *** hdl/olim_top.sv ***
// Purpose: limits the frequency command before it reaches the ramp generator
// Assumes: all inputs come from logic on ref_clk
// Notes: target frequency is registered one cycle after its inputs
//
// Behaviour
// - A maximum setting, 0 to 120 Hz and 120 Hz after reset, caps every command above it unless a higher minimum overrides it.
// - A minimum setting, 0 to 120 Hz and 0 Hz after reset, raises any lower command up to it.
// - A high-speed maximum, 120 to 400 Hz and 120 Hz after reset, is the upper limit for fast running.
// - Writing either the maximum or the high-speed maximum loads the same value into both.
// - In jog, a jog frequency at or below the minimum is output as is, skipping the minimum clamp.
// - While stall prevention lowers the frequency, the output may fall below the minimum.
// - With minimum at or above the starting frequency, start alone ramps the output to the minimum.
module olim_top #(
  parameter int NBAND = olim_pkg::NBAND
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // setting writes
  input wire logic wr_en,
  input wire logic [olim_pkg::SW-1:0] wr_sel,
  input wire logic [olim_pkg::FW-1:0] wr_data,
  input wire logic [7:0] extended_param_display_sel,
  output logic wr_done_r,
  output logic wr_refused_r,
  // command side
  input wire logic [olim_pkg::FW-1:0] freq_cmd,
  input wire logic start_req,
  input wire logic jog_req,
  input wire logic stall_lower,
  input wire logic [olim_pkg::FW-1:0] stall_freq,
  // ramp side
  output logic [olim_pkg::FW-1:0] target_freq_r,
  output logic run_r,
  output logic below_min_r,
  // setting readback
  output logic [olim_pkg::FW-1:0] max_freq_limit_r,
  output logic [olim_pkg::FW-1:0] min_freq_limit_r,
  output logic [olim_pkg::FW-1:0] high_speed_max_limit_r
);
  logic [olim_pkg::FW-1:0] jog_freq_setting_r;
  logic [olim_pkg::FW-1:0] starting_freq_setting_r;
  logic [olim_pkg::FW-1:0] jump_band_edges_r [2*NBAND];
  olim_pkg::olim_mode_t mode_nxt;
  logic wr_take;
  logic wr_limit;
  logic stall_active;
  logic [olim_pkg::FW-1:0] mode_freq;
  logic locked;
  logic in_range;
  logic guarded;
  logic is_jump;
  logic [olim_pkg::FW-1:0] upper;
  logic [olim_pkg::FW-1:0] capped;
  logic [olim_pkg::FW-1:0] clamped;
  logic [olim_pkg::FW-1:0] run_freq;
  logic [olim_pkg::FW-1:0] target_nxt;
  olim_jump_if jif ();
  // ********************************
  // write checking
  // ********************************
  assign is_jump = (wr_sel >= olim_pkg::SEL_JUMP0) && (wr_sel <= olim_pkg::SEL_JUMP_LAST);
  assign guarded = is_jump || (wr_sel == olim_pkg::SEL_HSMAX);
  assign locked = guarded && (extended_param_display_sel != olim_pkg::EXT_OPEN);
  always_comb begin
    in_range = 1'b0;
    if (is_jump) begin
      in_range = (wr_data <= olim_pkg::F_400HZ) || (wr_data == olim_pkg::F_DISABLED);
    end else begin
      unique case (wr_sel)
        olim_pkg::SEL_MAX, olim_pkg::SEL_MIN: in_range = wr_data <= olim_pkg::F_120HZ;
        olim_pkg::SEL_HSMAX: in_range = (wr_data >= olim_pkg::F_120HZ) && (wr_data <= olim_pkg::F_400HZ);
        olim_pkg::SEL_JOG, olim_pkg::SEL_START: in_range = wr_data <= olim_pkg::F_400HZ;
        default: in_range = 1'b0;
      endcase
    end
  end
  // ********************************
  // limit settings
  // ********************************
  assign wr_take = clk_en && wr_en && in_range && !locked;
  assign wr_limit = wr_take && (wr_sel == olim_pkg::SEL_MAX || wr_sel == olim_pkg::SEL_HSMAX);
  // both limits load together so the upper clamp never sees two values
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      max_freq_limit_r <= olim_pkg::MAX_RST;
    end else if (wr_limit) begin
      max_freq_limit_r <= wr_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      high_speed_max_limit_r <= olim_pkg::HSMAX_RST;
    end else if (wr_limit) begin
      high_speed_max_limit_r <= wr_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      min_freq_limit_r <= olim_pkg::MIN_RST;
    end else if (wr_take && wr_sel == olim_pkg::SEL_MIN) begin
      min_freq_limit_r <= wr_data;
    end
  end
  // ********************************
  // jog, start and jump settings
  // ********************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      jog_freq_setting_r <= olim_pkg::JOG_RST;
    end else if (wr_take && wr_sel == olim_pkg::SEL_JOG) begin
      jog_freq_setting_r <= wr_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      starting_freq_setting_r <= olim_pkg::START_RST;
    end else if (wr_take && wr_sel == olim_pkg::SEL_START) begin
      starting_freq_setting_r <= wr_data;
    end
  end
  // each edge has its own write strobe
  for (genvar e = 0; e < 2*NBAND; e++) begin : g_edge
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        jump_band_edges_r[e] <= olim_pkg::JUMP_RST;
      end else if (wr_take && wr_sel == olim_pkg::SW'(olim_pkg::SEL_JUMP0 + e)) begin
        jump_band_edges_r[e] <= wr_data;
      end
    end
    assign jif.edges[e] = jump_band_edges_r[e];
  end
  // ********************************
  // write status
  // ********************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_done_r <= 1'b0;
    end else if (clk_en) begin
      wr_done_r <= wr_take;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_refused_r <= 1'b0;
    end else if (clk_en) begin
      wr_refused_r <= wr_en && !(in_range && !locked);
    end
  end
  // ********************************
  // clamping
  // ********************************
  // upper limit is the maximum, kept equal to the high-speed maximum
  assign upper = max_freq_limit_r;
  assign capped = (freq_cmd > upper) ? upper : freq_cmd;
  assign clamped = (capped < min_freq_limit_r) ? min_freq_limit_r : capped;
  assign jif.cmd = clamped;
  olim_jump u_jump (
    .jp(jif)
  );
  // start alone gives the minimum; below starting frequency the ramp stays at rest
  assign run_freq = (jif.result < starting_freq_setting_r) ? olim_pkg::F_ZERO : jif.result;
  // ********************************
  // mode decode
  // ********************************
  always_comb begin
    mode_nxt = olim_pkg::OLIM_IDLE;
    if (start_req) begin
      mode_nxt = olim_pkg::OLIM_RUN;
    end else if (jog_req) begin
      mode_nxt = olim_pkg::OLIM_JOG;
    end
  end
  // ********************************
  // target select
  // ********************************
  always_comb begin
    mode_freq = olim_pkg::F_ZERO;
    unique case (mode_nxt)
      olim_pkg::OLIM_IDLE: mode_freq = olim_pkg::F_ZERO;
      olim_pkg::OLIM_RUN: mode_freq = run_freq;
      olim_pkg::OLIM_JOG: begin
        if (jog_freq_setting_r <= min_freq_limit_r) begin
          mode_freq = jog_freq_setting_r;
        end else begin
          mode_freq = (jog_freq_setting_r > upper) ? upper : jog_freq_setting_r;
        end
      end
    endcase
  end
  // ********************************
  // stall prevention
  // ********************************
  // stall may pull the target under the minimum, never above the limited value
  assign stall_active = stall_lower && (mode_nxt != olim_pkg::OLIM_IDLE) && (stall_freq < mode_freq);
  assign target_nxt = stall_active ? stall_freq : mode_freq;
  // ********************************
  // ramp side outputs
  // ********************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      target_freq_r <= olim_pkg::F_ZERO;
    end else if (clk_en) begin
      target_freq_r <= target_nxt;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      run_r <= 1'b0;
    end else if (clk_en) begin
      run_r <= mode_nxt != olim_pkg::OLIM_IDLE;
    end
  end
  // flags a running target under the minimum, as stall or jog may give
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      below_min_r <= 1'b0;
    end else if (clk_en) begin
      below_min_r <= (mode_nxt != olim_pkg::OLIM_IDLE) && (target_nxt < min_freq_limit_r);
    end
  end
endmodule

// *** verif/olim_ramp_model.sv ***
// Purpose: acceleration ramp that follows the limited target
// Assumes: one step per cycle, towards zero when not running
// Notes: stands in for the ramp generator
module olim_ramp_model #(
  parameter int STEP = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // limiter side
  input wire logic run_r,
  input wire logic [olim_pkg::FW-1:0] target_freq_r,
  output logic [olim_pkg::FW-1:0] ramp_freq
);
  logic [olim_pkg::FW-1:0] goal;
  assign goal = run_r ? target_freq_r : olim_pkg::F_ZERO;
  // ramps to the target at the set rate
  always_ff @(posedge ref_clk) begin
    if (!reset_n) ramp_freq <= olim_pkg::F_ZERO;
    else if (ramp_freq + STEP < goal) ramp_freq <= ramp_freq + 16'(STEP);
    else if (ramp_freq > goal + STEP) ramp_freq <= ramp_freq - 16'(STEP);
    else ramp_freq <= goal;
  end
endmodule

// *** verif/olim_top_sva.sv ***
// Purpose: port checks of the frequency limiter
// Assumes: single clock domain
// Notes: attached by bind
module olim_top_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // writes
  input wire logic wr_en,
  input wire logic [olim_pkg::SW-1:0] wr_sel,
  input wire logic [olim_pkg::FW-1:0] wr_data,
  input wire logic [7:0] extended_param_display_sel,
  input wire logic wr_done_r,
  input wire logic wr_refused_r,
  // command and outputs
  input wire logic [olim_pkg::FW-1:0] freq_cmd,
  input wire logic start_req,
  input wire logic jog_req,
  input wire logic stall_lower,
  input wire logic [olim_pkg::FW-1:0] stall_freq,
  input wire logic [olim_pkg::FW-1:0] target_freq_r,
  input wire logic run_r,
  input wire logic [olim_pkg::FW-1:0] max_freq_limit_r,
  input wire logic [olim_pkg::FW-1:0] high_speed_max_limit_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  limits_agree_a: assert property (max_freq_limit_r == high_speed_max_limit_r)
    else $error("max and high-speed max differ");
  max_cap_a: assert property (clk_en && start_req && !wr_en && freq_cmd > max_freq_limit_r
    |=> target_freq_r <= $past(max_freq_limit_r)) else $error("target above max");
  max_range_a: assert property (clk_en && wr_en && wr_sel == olim_pkg::SEL_MAX
    && wr_data > olim_pkg::F_120HZ |=> wr_refused_r && !wr_done_r) else $error("max range kept open");
  hs_write_a: assert property (clk_en && wr_en && wr_sel == olim_pkg::SEL_HSMAX &&
    extended_param_display_sel == olim_pkg::EXT_OPEN && wr_data inside {[olim_pkg::F_120HZ:olim_pkg::F_400HZ]}
    |=> wr_done_r && max_freq_limit_r == $past(wr_data)) else $error("high-speed write lost");
  lock_refuse_a: assert property (clk_en && wr_en && extended_param_display_sel != olim_pkg::EXT_OPEN
    && (wr_sel == olim_pkg::SEL_HSMAX || wr_sel >= olim_pkg::SEL_JUMP0) |=> wr_refused_r
    && $stable(high_speed_max_limit_r)) else $error("locked write taken");
  stall_low_a: assert property (clk_en && start_req && stall_lower
    |=> target_freq_r <= $past(stall_freq)) else $error("stall not followed");
  run_flag_a: assert property (clk_en && (start_req || jog_req) |=> run_r)
    else $error("run not raised");
  idle_zero_a: assert property (clk_en && !start_req && !jog_req |=> !run_r && target_freq_r == 16'h0000)
    else $error("idle target not zero");
  freeze_a: assert property (!clk_en && reset_n ##1 reset_n |-> $stable(target_freq_r) && $stable(run_r))
    else $error("outputs moved while frozen");
endmodule

// *** verif/testbench.sv ***
// Purpose: directed test of the frequency limiter
// Assumes: settings written one pulse at a time
// Notes: values in 0.1 Hz
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, reset_n = 0, clk_en = 1, wr_en = 0, start_req = 0, jog_req = 0, stall_lower = 0;
  logic [olim_pkg::SW-1:0] wr_sel = 4'h0;
  logic [7:0] ext_sel = 8'h00;
  logic [olim_pkg::FW-1:0] wr_data = 16'h0000, freq_cmd = 16'h0000, stall_freq = 16'h001e;
  logic [olim_pkg::FW-1:0] target_freq_r, max_r, min_r, hs_r, ramp_freq;
  logic wr_done_r, wr_refused_r, run_r, below_min_r;
  int miscompares = 0, compares = 0;
  initial forever #5 ref_clk = ~ref_clk;
  olim_top dut (.ref_clk, .reset_n, .clk_en, .wr_en, .wr_sel, .wr_data, .extended_param_display_sel(ext_sel),
    .wr_done_r, .wr_refused_r, .freq_cmd, .start_req, .jog_req, .stall_lower, .stall_freq, .target_freq_r,
    .run_r, .below_min_r, .max_freq_limit_r(max_r), .min_freq_limit_r(min_r), .high_speed_max_limit_r(hs_r));
  olim_ramp_model ramp (.ref_clk, .reset_n, .run_r, .target_freq_r, .ramp_freq);
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wr(input logic [3:0] s, input logic [15:0] d, input logic ok);
    @(posedge ref_clk);
    wr_en <= 1;
    wr_sel <= s;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 0;
    #1 check(16'(wr_done_r), 16'(ok));
    check(16'(wr_refused_r), 16'(!ok));
  endtask
  task cmd(input logic s, input logic j, input logic st, input logic [15:0] f, input logic [15:0] exp);
    @(posedge ref_clk);
    start_req <= s;
    jog_req <= j;
    stall_lower <= st;
    freq_cmd <= f;
    @(posedge ref_clk);
    #1 check(target_freq_r, exp);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1;
    #1 check(max_r, 16'h04b0);
    check(min_r, 16'h0000);
    check(hs_r, 16'h04b0);
    cmd(1, 0, 0, 16'h07d0, 16'h04b0);
    wr(olim_pkg::SEL_MAX, 16'h0258, 1);
    check(hs_r, 16'h0258);
    wr(olim_pkg::SEL_HSMAX, 16'h0bb8, 1);
    check(max_r, 16'h0bb8);
    cmd(1, 0, 0, 16'h0dac, 16'h0bb8);
    wr(olim_pkg::SEL_HSMAX, 16'h044c, 0);
    wr(olim_pkg::SEL_HSMAX, 16'h0fa1, 0);
    wr(olim_pkg::SEL_MAX, 16'h04b1, 0);
    $display("test upper limits done");
    @(posedge ref_clk) ext_sel <= 8'h01;
    wr(olim_pkg::SEL_HSMAX, 16'h07d0, 0);
    wr(olim_pkg::SEL_JUMP0, 16'h0190, 0);
    check(hs_r, 16'h0bb8);
    @(posedge ref_clk) ext_sel <= 8'h00;
    wr(olim_pkg::SEL_MAX, 16'h04b0, 1);
    wr(olim_pkg::SEL_MIN, 16'h0064, 1);
    cmd(1, 0, 0, 16'h0032, 16'h0064);
    cmd(1, 0, 0, 16'h0000, 16'h0064);
    for (int i = 0; i < 400 && ramp_freq !== 16'h0064; i++) @(posedge ref_clk);
    check(ramp_freq, 16'h0064);
    if (ramp_freq !== 16'h0064) stop_test();
    cmd(0, 1, 0, 16'h0258, 16'h0032);
    wr(olim_pkg::SEL_JOG, 16'h012c, 1);
    cmd(0, 1, 0, 16'h0000, 16'h012c);
    wr(olim_pkg::SEL_START, 16'h0096, 1);
    cmd(1, 0, 0, 16'h0000, 16'h0000);
    wr(olim_pkg::SEL_START, 16'h0005, 1);
    cmd(1, 0, 1, 16'h0064, 16'h001e);
    check(16'(below_min_r), 16'h0001);
    $display("test lower limit done");
    for (int i = 8; i < 14; i++) wr(4'(i), 16'h270f, 1);
    wr(olim_pkg::SEL_JUMP0, 16'h0258, 1);
    wr(4'h9, 16'h0190, 1);
    cmd(1, 0, 0, 16'h01f4, 16'h0190);
    cmd(1, 0, 0, 16'h0258, 16'h0258);
    wr(4'h9, 16'h0fa1, 0);
    wr(4'h9, 16'h270f, 1);
    cmd(1, 0, 0, 16'h01f4, 16'h01f4);
    @(posedge ref_clk);
    clk_en <= 0;
    freq_cmd <= 16'h0320;
    repeat (3) @(posedge ref_clk);
    #1 check(target_freq_r, 16'h01f4);
    @(posedge ref_clk) clk_en <= 1;
    $display("test jump bands done");
    stop_test();
  end
endmodule
bind olim_top olim_top_sva chk (.ref_clk, .reset_n, .clk_en, .wr_en, .wr_sel, .wr_data,
  .extended_param_display_sel, .wr_done_r, .wr_refused_r, .freq_cmd, .start_req, .jog_req, .stall_lower,
  .stall_freq, .target_freq_r, .run_r, .max_freq_limit_r, .high_speed_max_limit_r);
